// ---- hdl/gen_settings.v ----
// ****************************************************************
// generator output state settings
// ****************************************************************
// apb register block holding output settings, saved slots and triggers
// assumes a power-on reset on rst_b_in and an asynchronous system reset pin, synchronised here
`timescale 1ns/1ps
`include "gen_settings_consts.vh"
module gen_settings #(
  parameter SLOTS   = 4,
  parameter LINES   = 8,
  parameter POINT_W = 12
) (
  input  wire             clk_sys_in,
  input  wire             rst_b_in,
  input  wire             sys_reset_b_in,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  input  wire             sync_source_in,
  output reg              sync_out,
  output reg              front_trigger_out,
  output reg  [LINES-1:0] backplane_trigger_drive_out,
  output reg  [LINES-1:0] backplane_trigger_oe_out,
  output reg              output_termination_select_out,
  output reg              nv_waveform_resume_out
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_CHECK = 2'd1;
  localparam ST_APPLY = 2'd2;
  localparam PULSE_CYC = `TRIG_PULSE_CYC;

  // ****************************************************************
  // state
  // ****************************************************************
  reg [`CTRL_WIDTH-1:0] ctrl;
  reg [LINES-1:0]       trig_en;
  reg [`CTRL_WIDTH-1:0] slot_ctrl [0:SLOTS-1];
  reg [LINES-1:0]       slot_trig [0:SLOTS-1];
  reg [SLOTS-1:0]       slot_used;
  reg [15:0]            error_code;
  reg [1:0]             boot_state;
  reg                   boot_power;
  reg [7:0]             pulse_cnt;
  reg                   sys_meta;
  reg                   sys_sync;
  reg                   sys_prev;
  reg                   sync_meta;
  reg                   sync_sync;
  reg                   boot_pending;
  integer               i;

  wire                  wr_en;
  wire                  rd_en;
  wire                  cmd_wr;
  wire [3:0]            cmd_op;
  wire [1:0]            cmd_slot;
  wire                  sys_fall;
  wire [7:0]            pk_byte;
  wire [POINT_W-1:0]    pk_point;
  wire                  pk_done;
  reg  [POINT_W-1:0]    point_hold;

  function addr_hit;
    input [11:0] a;
    input [11:0] b;
    begin
      addr_hit = (a == b);
    end
  endfunction

  // ****************************************************************
  // apb slave, zero wait states
  // ****************************************************************
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & penable & ~pwrite;
  assign pslverr  = psel & penable & (paddr > `ADDR_ERROR);
  assign cmd_wr   = wr_en & addr_hit(paddr, `ADDR_CMD);
  assign cmd_op   = pwdata[3:0];
  assign cmd_slot = pwdata[5:4];

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sys_meta  <= 1'b1;
      sys_sync  <= 1'b1;
      sys_prev  <= 1'b1;
      sync_meta <= 1'b0;
      sync_sync <= 1'b0;
    end else begin
      sys_meta  <= sys_reset_b_in;
      sys_sync  <= sys_meta;
      sys_prev  <= sys_sync;
      sync_meta <= sync_source_in;
      sync_sync <= sync_meta;
    end
  end
  assign sys_fall = sys_prev & ~sys_sync;

  // ****************************************************************
  // settings, slots and startup sequence
  // ****************************************************************
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl         <= `CTRL_RESET_VAL;
      trig_en      <= {LINES{1'b0}};
      error_code   <= `ERR_NONE;
      boot_state   <= ST_CHECK;
      boot_power   <= 1'b1;
      boot_pending <= 1'b0;
      pulse_cnt    <= 8'h00;
      for (i = 0; i < SLOTS; i = i + 1) begin
        slot_ctrl[i] <= `CTRL_RESET_VAL;
        slot_trig[i] <= {LINES{1'b0}};
      end
      slot_used    <= {{(SLOTS-1){1'b0}}, 1'b1};
    end else begin
      if (pulse_cnt != 8'h00) begin
        pulse_cnt <= pulse_cnt - 8'h01;
      end
      case (boot_state)
        ST_CHECK: begin
          // checksum fault needs slot 0 unused while boot_power is set; reset marks slot 0 used, so it never fires
          if (boot_power && !slot_used[0]) begin
            error_code <= `ERR_CHECKSUM;
          end
          boot_state <= ST_APPLY;
        end
        ST_APPLY: begin
          if (slot_used[0] && slot_ctrl[0][`CTRL_AUTO_BIT]) begin
            ctrl    <= slot_ctrl[0];
            trig_en <= slot_trig[0];
          end else begin
            ctrl    <= `CTRL_RESET_VAL;
            trig_en <= {LINES{1'b0}};
          end
          boot_power <= 1'b0;
          boot_state <= ST_IDLE;
        end
        ST_IDLE: begin
          if (sys_fall) begin
            boot_state <= ST_CHECK;
          end else if (wr_en && addr_hit(paddr, `ADDR_CTRL)) begin
            ctrl <= pwdata[`CTRL_WIDTH-1:0];
          end else if (wr_en && addr_hit(paddr, `ADDR_TRIG_EN)) begin
            trig_en <= pwdata[LINES-1:0];
          end else if (wr_en && addr_hit(paddr, `ADDR_ERROR)) begin
            error_code <= `ERR_NONE;
          end else if (cmd_wr) begin
            case (cmd_op)
              `CMD_SAVE: begin
                slot_ctrl[cmd_slot] <= ctrl;
                slot_trig[cmd_slot] <= trig_en;
                slot_used[cmd_slot] <= 1'b1;
              end
              `CMD_RECALL: begin
                if (slot_used[cmd_slot]) begin
                  ctrl    <= slot_ctrl[cmd_slot];
                  trig_en <= slot_trig[cmd_slot];
                end else begin
                  error_code <= `ERR_NOT_STORED;
                end
              end
              `CMD_DELETE: begin
                if (slot_used[cmd_slot]) begin
                  slot_used[cmd_slot] <= 1'b0;
                  slot_ctrl[cmd_slot] <= `CTRL_RESET_VAL;
                  slot_trig[cmd_slot] <= {LINES{1'b0}};
                end else begin
                  error_code <= `ERR_NOT_STORED;
                end
              end
              `CMD_TRIGGER: begin
                pulse_cnt <= PULSE_CYC[7:0];
              end
              default: begin
                boot_pending <= boot_pending;
              end
            endcase
          end
        end
        default: begin
          boot_state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_out                      <= 1'b0;
      front_trigger_out             <= 1'b0;
      backplane_trigger_drive_out   <= {LINES{1'b1}};
      backplane_trigger_oe_out      <= {LINES{1'b0}};
      output_termination_select_out <= 1'b0;
      nv_waveform_resume_out        <= 1'b0;
    end else begin
      // disabled sync is held low; the level carries no meaning
      sync_out <= ctrl[`CTRL_SYNC_BIT] & sync_sync;
      // compat trigger state bit plays no part here
      front_trigger_out <= (pulse_cnt != 8'h00);
      backplane_trigger_drive_out <= {LINES{pulse_cnt == 8'h00}};
      backplane_trigger_oe_out    <= trig_en & {LINES{pulse_cnt != 8'h00}};
      output_termination_select_out <= ctrl[`CTRL_LOAD_BIT];
      nv_waveform_resume_out <= ctrl[`CTRL_NVWAVE_BIT] & (boot_state == ST_IDLE);
    end
  end

  // ****************************************************************
  // byte-order packing of block transfer points
  // ****************************************************************
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      point_hold <= {POINT_W{1'b0}};
    end else if (wr_en && addr_hit(paddr, `ADDR_POINT_IN)) begin
      point_hold <= pwdata[POINT_W-1:0];
    end
  end

  point_byte_packer #(
    .POINT_W (POINT_W)
  ) u_packer (
    .clk_sys_in     (clk_sys_in),
    .rst_b_in       (rst_b_in),
    .swap_in        (ctrl[`CTRL_SWAP_BIT]),
    .clear_in       (boot_state != ST_IDLE),
    .load_point_in  (wr_en & addr_hit(paddr, `ADDR_POINT_IN)),
    .point_in       (pwdata[POINT_W-1:0]),
    .byte_wr_in     (wr_en & addr_hit(paddr, `ADDR_BYTE_IN)),
    .byte_in        (pwdata[7:0]),
    .byte_rd_in     (rd_en & addr_hit(paddr, `ADDR_BYTE_OUT)),
    .byte_out       (pk_byte),
    .point_out      (pk_point),
    .point_done_out (pk_done)
  );

  // ****************************************************************
  // read mux
  // ****************************************************************
  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `ADDR_CTRL:       prdata = {26'h000_0000, ctrl};
      `ADDR_TRIG_EN:    prdata = {24'h00_0000, trig_en};
      `ADDR_STATUS:     prdata = {20'h0_0000, pk_done, 3'b000,
                                  {(8-SLOTS){1'b0}}, slot_used};
      `ADDR_ORDER_TEXT: prdata = ctrl[`CTRL_SWAP_BIT] ? `TEXT_SWAP : `TEXT_HIGH_BYTE_FIRST;
      `ADDR_LOAD_TEXT:  prdata = ctrl[`CTRL_LOAD_BIT] ? `TEXT_LOAD_INF : `TEXT_LOAD_50;
      `ADDR_POINT_IN:   prdata = {20'h0_0000, point_hold};
      `ADDR_POINT_OUT:  prdata = {20'h0_0000, pk_point};
      `ADDR_BYTE_OUT:   prdata = {24'h00_0000, pk_byte};
      `ADDR_ERROR:      prdata = {16'h0000, error_code};
      default:          prdata = 32'h0000_0000;
    endcase
  end
endmodule

// ---- hdl/gen_settings_consts.vh ----
// constants for the generator output state settings block
// assumes an apb master on the system clock and a byte-wide transfer path
`ifndef GEN_SETTINGS_CONSTS_VH
`define GEN_SETTINGS_CONSTS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define ADDR_CTRL        12'h000
`define ADDR_TRIG_EN     12'h004
`define ADDR_CMD         12'h008
`define ADDR_STATUS      12'h00C
`define ADDR_ORDER_TEXT  12'h010
`define ADDR_LOAD_TEXT   12'h014
`define ADDR_POINT_IN    12'h018
`define ADDR_POINT_OUT   12'h01C
`define ADDR_BYTE_IN     12'h020
`define ADDR_BYTE_OUT    12'h024
`define ADDR_ERROR       12'h028

// ****************************************************************
// control fields
// ****************************************************************
`define CTRL_SWAP_BIT    0
`define CTRL_SYNC_BIT    1
`define CTRL_LOAD_BIT    2
`define CTRL_AUTO_BIT    3
`define CTRL_COMPAT_BIT  4
`define CTRL_NVWAVE_BIT  5
`define CTRL_WIDTH       6
`define CTRL_RESET_VAL   6'h02

// command codes: bits 3:0 op, bits 5:4 slot
`define CMD_SAVE         4'h1
`define CMD_RECALL       4'h2
`define CMD_DELETE       4'h3
`define CMD_TRIGGER      4'h4

// ****************************************************************
// answers and errors
// ****************************************************************
`define TEXT_HIGH_BYTE_FIRST        32'h4E4F_524D
`define TEXT_SWAP        32'h5357_4150
`define TEXT_LOAD_50     32'h0000_3530
`define TEXT_LOAD_INF    32'h3945_3337
`define ERR_NONE         16'h0000
`define ERR_NOT_STORED   16'h032A
`define ERR_CHECKSUM     16'h0304

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS    10
`define TRIG_PULSE_NS    100
`define TRIG_PULSE_CYC   ((`TRIG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- hdl/point_byte_packer.v ----
// ****************************************************************
// point byte packer
// ****************************************************************
// splits a 12-bit point into two bytes and joins two bytes into a point
// assumes the caller strobes one byte at a time on the system clock
`timescale 1ns/1ps
module point_byte_packer #(
  parameter POINT_W = 12
) (
  input  wire               clk_sys_in,
  input  wire               rst_b_in,
  input  wire               swap_in,
  input  wire               clear_in,
  input  wire               load_point_in,
  input  wire [POINT_W-1:0] point_in,
  input  wire               byte_wr_in,
  input  wire [7:0]         byte_in,
  input  wire               byte_rd_in,
  output reg  [7:0]         byte_out,
  output reg  [POINT_W-1:0] point_out,
  output reg                point_done_out
);
  reg [15:0] tx_word;
  reg        tx_half;
  reg [7:0]  rx_first;
  reg        rx_half;
  wire [15:0] rx_word;

  // second byte combines with the held first one in the chosen order
  assign rx_word = swap_in ? {byte_in, rx_first} : {rx_first, byte_in};

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_word        <= 16'h0000;
      tx_half        <= 1'b0;
      rx_first       <= 8'h00;
      rx_half        <= 1'b0;
      byte_out       <= 8'h00;
      point_out      <= {POINT_W{1'b0}};
      point_done_out <= 1'b0;
    end else begin
      point_done_out <= 1'b0;
      if (clear_in) begin
        tx_half <= 1'b0;
        rx_half <= 1'b0;
      end else begin
        if (load_point_in) begin
          tx_word  <= {{(16-POINT_W){1'b0}}, point_in};
          tx_half  <= 1'b0;
          byte_out <= swap_in ? point_in[7:0] : {{(16-POINT_W){1'b0}}, point_in[POINT_W-1:8]};
        end else if (byte_rd_in) begin
          tx_half  <= ~tx_half;
          byte_out <= (swap_in ^ tx_half) ? tx_word[15:8] : tx_word[7:0];
        end
        if (byte_wr_in) begin
          if (!rx_half) begin
            rx_first <= byte_in;
            rx_half  <= 1'b1;
          end else begin
            rx_half        <= 1'b0;
            point_out      <= rx_word[POINT_W-1:0];
            point_done_out <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ---- testbench/gen_settings_monitor.sv ----
// checker for the output state settings block
// assumes it is bound to gen_settings and sees only its ports
`timescale 1ns/1ps
`include "gen_settings_consts.vh"
module gen_settings_monitor #(
  parameter LINES = 8
) (
  input wire logic             clk_sys_in,
  input wire logic             rst_b_in,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             front_trigger_out,
  input wire logic [LINES-1:0] backplane_trigger_drive_out,
  input wire logic [LINES-1:0] backplane_trigger_oe_out
);
  // ****************************************************************
  // helper logic and properties
  // ****************************************************************
  logic trig_req;
  logic acc_rd;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  assign acc_rd = psel && penable && !pwrite;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trig_req <= 1'b0;
    end else begin
      trig_req <= psel && penable && pwrite && paddr == `ADDR_CMD
                  && pwdata[3:0] == `CMD_TRIGGER;
    end
  end
  property p_trig_cmd;
    trig_req |=> front_trigger_out;
  endproperty
  a_trig_cmd: assert property (p_trig_cmd) else $error("no trigger pulse");
  property p_rose_cause;
    $rose(front_trigger_out) |-> $past(trig_req);
  endproperty
  a_rose_cause: assert property (p_rose_cause) else $error("stray pulse");
  property p_pulse_len;
    $rose(front_trigger_out) |-> front_trigger_out[*8] ##1 front_trigger_out[*2]
      ##1 !front_trigger_out;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length");
  property p_drive;
    (backplane_trigger_oe_out & backplane_trigger_drive_out) == '0;
  endproperty
  a_drive: assert property (p_drive) else $error("line not pulled low");
  property p_oe_front;
    |backplane_trigger_oe_out |-> front_trigger_out;
  endproperty
  a_oe_front: assert property (p_oe_front) else $error("line pulse alone");
  property p_oe_stable;
    front_trigger_out && $past(front_trigger_out) |-> $stable(backplane_trigger_oe_out);
  endproperty
  a_oe_stable: assert property (p_oe_stable) else $error("line pulse moved");
  property p_order;
    acc_rd && paddr == `ADDR_ORDER_TEXT |-> prdata == `TEXT_HIGH_BYTE_FIRST || prdata == `TEXT_SWAP;
  endproperty
  a_order: assert property (p_order) else $error("bad order text");
  property p_load;
    acc_rd && paddr == `ADDR_LOAD_TEXT |-> prdata == `TEXT_LOAD_50 || prdata == `TEXT_LOAD_INF;
  endproperty
  a_load: assert property (p_load) else $error("bad load text");
  c_trig: cover property ($rose(front_trigger_out));
  c_swap: cover property (acc_rd && paddr == `ADDR_ORDER_TEXT && prdata == `TEXT_SWAP);
  c_inf: cover property (acc_rd && paddr == `ADDR_LOAD_TEXT && prdata == `TEXT_LOAD_INF);
endmodule
bind gen_settings gen_settings_monitor #(.LINES(LINES)) i_gen_settings_monitor (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .front_trigger_out(front_trigger_out),
  .backplane_trigger_drive_out(backplane_trigger_drive_out),
  .backplane_trigger_oe_out(backplane_trigger_oe_out));

// ---- testbench/host_apb_model.sv ----
// host controller model: apb master issuing settings commands
// assumes the slave answers with pready; waits are cut by the bench timeout
`timescale 1ns/1ps
module host_apb_model (
  input  wire logic        clk_sys_in,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic last_err;
  initial begin
    last_err = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // one transfer; released lines show the inverse of the last value
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ---- testbench/generator_output_state_settings_bench.sv ----
// self-checking bench for the output state settings block
// assumes the host model drives apb and a behavioural model predicts results
`timescale 1ns/1ps
`include "gen_settings_consts.vh"
module generator_output_state_settings_bench;
  logic clk_sys_in = 0, rst_b_in = 0, sys_reset_b_in = 1, sync_source_in = 0;
  logic psel, penable, pwrite, pready, pslverr, sync_out, front_trigger_out;
  logic output_termination_select_out, nv_waveform_resume_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  drv, oe;
  logic [2:0]  src_d = 3'b000;
  int n_errors = 0, n_compared = 0, cyc = 0, ctrl_m, en_m, p, b, s, sv[4];
  bit used[4];
  gen_settings i_gen_settings (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .sys_reset_b_in(sys_reset_b_in), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_source_in(sync_source_in), .sync_out(sync_out),
    .front_trigger_out(front_trigger_out), .backplane_trigger_drive_out(drv),
    .backplane_trigger_oe_out(oe),
    .output_termination_select_out(output_termination_select_out),
    .nv_waveform_resume_out(nv_waveform_resume_out));
  host_apb_model i_host_apb_model (.clk_sys_in(clk_sys_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  initial forever #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    sync_source_in <= $urandom;
    src_d <= {src_d[1:0], sync_source_in};
    if (cyc == 20000) begin
      n_errors++;
      finish_test;
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input int d);
    i_host_apb_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a);
    i_host_apb_model.xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic cmd(input int op, input int sl);
    wr(`ADDR_CMD, (sl << 4) | op);
    if (op == 1) begin
      sv[sl] = ctrl_m;
      used[sl] = 1;
    end else if (op == 3) begin
      rd(`ADDR_ERROR);
      chk(q[15:0], used[sl] ? `ERR_NONE : `ERR_NOT_STORED);
      used[sl] = 0;
      wr(`ADDR_ERROR, 0);
    end
  endtask
  task automatic sys_pulse;
    @(posedge clk_sys_in) sys_reset_b_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    sys_reset_b_in <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    ctrl_m = (sv[0] >> `CTRL_AUTO_BIT) & 1 ? sv[0] : 32'h0000_0002;
    rd(`ADDR_CTRL);
    chk(q[5:0], ctrl_m);
  endtask
  task automatic finish_test;
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    void'($urandom(32'h2c51));
    ctrl_m = 2;
    sv[0] = 2;
    used[0] = 1;
    repeat (6) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    rd(`ADDR_CTRL);
    chk(q[5:0], `CTRL_RESET_VAL);
    rd(`ADDR_TRIG_EN);
    chk(q[7:0], 8'h00);
    rd(`ADDR_STATUS);
    chk(q[3:0], 4'h1);
    repeat (4) begin
      ctrl_m = $urandom & 32'h0000_0037;
      wr(`ADDR_CTRL, ctrl_m);
      rd(`ADDR_CTRL);
      chk(q[5:0], ctrl_m);
      rd(`ADDR_ORDER_TEXT);
      chk(q, ctrl_m[0] ? `TEXT_SWAP : `TEXT_HIGH_BYTE_FIRST);
      chk(i_host_apb_model.last_err, 1'b0);
      rd(`ADDR_LOAD_TEXT);
      chk(q, ctrl_m[2] ? `TEXT_LOAD_INF : `TEXT_LOAD_50);
      chk({output_termination_select_out, nv_waveform_resume_out}, ctrl_m[2] * 2 + ctrl_m[5]);
      #1;
      if (ctrl_m[1]) chk(sync_out, src_d[2]);
    end
    for (s = 0; s < 2; s++) begin
      ctrl_m = 2 | s;
      wr(`ADDR_CTRL, ctrl_m);
      p = $urandom & 32'h0000_0fff;
      wr(`ADDR_POINT_IN, p);
      rd(`ADDR_BYTE_OUT);
      chk(q[7:0], s ? p & 8'hff : p >> 8);
      rd(`ADDR_BYTE_OUT);
      chk(q[7:0], s ? p >> 8 : p & 8'hff);
      p = $urandom & 32'h0000_0fff;
      wr(`ADDR_BYTE_IN, s ? p & 8'hff : p >> 8);
      wr(`ADDR_BYTE_IN, s ? p >> 8 : p & 8'hff);
      rd(`ADDR_POINT_OUT);
      chk(q[11:0], p);
    end
    for (b = 0; b < 3; b++) begin
      en_m = b == 0 ? 8'hff : $urandom & 8'hff;
      wr(`ADDR_TRIG_EN, en_m);
      rd(`ADDR_TRIG_EN);
      chk(q[7:0], en_m);
      wr(`ADDR_CMD, `CMD_TRIGGER);
      @(posedge clk_sys_in);
      #1 chk({front_trigger_out, oe, drv}, {1'b1, en_m[7:0], 8'h00});
      repeat (12) @(posedge clk_sys_in);
      chk({front_trigger_out, oe, drv}, {9'h000, 8'hff});
    end
    cmd(3, 2);
    cmd(1, 1);
    cmd(3, 1);
    cmd(3, 1);
    rd(`ADDR_STATUS);
    chk(q[3:0], 4'h1);
    ctrl_m = 32'h0000_002d;
    wr(`ADDR_CTRL, ctrl_m); // flag first, then save
    cmd(1, 0);
    wr(`ADDR_CTRL, 2);
    sys_pulse;
    chk(nv_waveform_resume_out, 1'b1);
    rd(`ADDR_TRIG_EN);
    chk(q[7:0], en_m);
    ctrl_m = 32'h0000_0024;
    wr(`ADDR_CTRL, ctrl_m);
    cmd(1, 0);
    sys_pulse;
    rd(`ADDR_TRIG_EN);
    chk(q[7:0], 8'h00);
    rd(12'h030);
    chk(q, 32'h0000_0000);
    chk(i_host_apb_model.last_err, 1'b1);
    finish_test;
  end
endmodule
